/* File: src/rhpd_top.sv */
// Purpose: root hub descriptor A/B registers and port power switching
// Assumes: register strobes and port commands come from logic on mclk_i
// Notes:   read data is valid in the cycle after reg_rd_i
//
// How it works
// - no-power-switch flag set keeps every existing port powered
// - mode select only matters while no-power-switch flag is clear
// - ganged mode switches all ports together
// - per-port mode: masked ports take port commands, others global ones
// - port count field is 8 bits, value between 1 and 15
// - port power mask sits in descriptor B bits 31..16, bit 0 reserved
// - mask is ignored while ganged mode is selected
// - device fixed bits in 15..0, bit 0 reserved, set means fixed
// - mask resets with bit 17 set, bit 18 set only for two ports
// - ganged mode: writing 1 to set global power powers all ports
// - per-port mode: set global power acts only on unmasked ports
`timescale 1ns/1ps
`default_nettype none

`include "rhpd_cfg.svh"

module rhpd_top
	import rhpd_pkg::*;
#(
	parameter bit TWO_PORT = 1'b1
) (
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [31:0] reg_wdata_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic [15:0] port_set_pwr_i,
	input  wire logic [15:0] port_clr_pwr_i,
	output logic      [15:0] port_pwr_o,
	output logic             no_power_switch_flag_o,
	output logic      [15:0] device_fixed_bits_o
);

	localparam int NPORTS = TWO_PORT ? 2 : 1;

	// ==========================================================
	// register state
	logic [7:0]    pwr_good_time_r;
	logic          no_ovc_prot_r;
	logic          ovc_per_port_r;
	logic          no_power_switch_flag_r;
	logic          power_switch_mode_sel_r;
	rhpd_portvec_t port_power_mask_r;
	rhpd_portvec_t device_fixed_bits_r;
	logic [31:0]   rdata_r;
	logic [31:0]   rdata_nxt;

	// ==========================================================
	// address decode and register images
	wire        sel_a    = (reg_addr_i == `RHPD_OFF_DESC_A);
	wire        sel_b    = (reg_addr_i == `RHPD_OFF_DESC_B);
	wire        sel_stat = (reg_addr_i == `RHPD_OFF_HUB_STAT);
	wire        wr_a     = reg_wr_i & sel_a;
	wire        wr_b     = reg_wr_i & sel_b;
	wire        wr_stat  = reg_wr_i & sel_stat;
	// port count is fixed by the build, never by software
	wire [7:0]  downstream_port_count =
		TWO_PORT ? `RHPD_NPORT_2P : `RHPD_NPORT_1P;
	wire [31:0] desc_a_img = {pwr_good_time_r, 11'h000, no_ovc_prot_r,
		ovc_per_port_r, 1'b0, no_power_switch_flag_r,
		power_switch_mode_sel_r, downstream_port_count};
	wire [31:0] desc_b_img = {port_power_mask_r,
		device_fixed_bits_r};
	wire [15:0] mask_rst = TWO_PORT ? `RHPD_MASK_RST_2P
		: `RHPD_MASK_RST_1P;

	// only a written 1 acts; a written 0 is no command
	wire set_global_power = wr_stat
		& reg_wdata_i[`RHPD_SET_GLOBAL_BIT];
	wire clr_global_power = wr_stat & reg_wdata_i[`RHPD_CLR_GLOBAL_BIT];

	// ==========================================================
	// descriptor A
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pwr_good_time_r         <= `RHPD_PG_TIME_RST;
			no_ovc_prot_r           <= `RHPD_NO_OVC_RST;
			ovc_per_port_r          <= `RHPD_OVC_MODE_RST;
			no_power_switch_flag_r  <= `RHPD_NO_PWR_SW_RST;
			power_switch_mode_sel_r <= `RHPD_SW_MODE_RST;
		end else if (wr_a) begin
			pwr_good_time_r <=
				reg_wdata_i[`RHPD_PG_TIME_LSB +: 8];
			no_ovc_prot_r <=
				reg_wdata_i[`RHPD_NO_OVC_BIT];
			ovc_per_port_r <=
				reg_wdata_i[`RHPD_OVC_MODE_BIT];
			no_power_switch_flag_r <=
				reg_wdata_i[`RHPD_NO_PWR_SW_BIT];
			power_switch_mode_sel_r <=
				reg_wdata_i[`RHPD_SW_MODE_BIT];
		end
	end

	// ==========================================================
	// descriptor B; reserved bit 0 of each half stays zero
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			port_power_mask_r   <= mask_rst;
			device_fixed_bits_r <= `RHPD_FIXED_RST;
		end else if (wr_b) begin
			port_power_mask_r   <= reg_wdata_i[31:16]
				& `RHPD_MASK_WR;
			device_fixed_bits_r <= reg_wdata_i[15:0]
				& `RHPD_FIXED_WR;
		end
	end

	// ==========================================================
	// read path; unmapped and status reads return zero
	assign rdata_nxt = !reg_rd_i ? 32'h0000_0000
		: sel_a ? desc_a_img
		: sel_b ? desc_b_img
		: 32'h0000_0000;

	always_ff @(posedge mclk_i) begin
		if (reset_i)
			rdata_r <= 32'h0000_0000;
		else
			rdata_r <= rdata_nxt;
	end

	assign reg_rdata_o = rdata_r;

	// ==========================================================
	// switching mode decode
	rhpd_sw_mode_e sw_mode;
	assign sw_mode = no_power_switch_flag_r ? RHPD_SW_NONE
		: power_switch_mode_sel_r ? RHPD_SW_PORT
		: RHPD_SW_GANGED;

	wire ganged   = (sw_mode == RHPD_SW_GANGED);
	wire per_port = (sw_mode == RHPD_SW_PORT);
	// in ganged mode a port command is taken as a command for all ports
	wire any_set  = |port_set_pwr_i[15:1];
	wire any_clr  = |port_clr_pwr_i[15:1];
	wire gang_set = set_global_power | any_set;
	wire gang_clr = clr_global_power | any_clr;

	rhpd_portvec_t port_here;
	rhpd_portvec_t port_set;
	rhpd_portvec_t port_clr;
	rhpd_portvec_t port_pwr;

	assign port_here[0] = 1'b0;
	assign port_set[0]  = 1'b0;
	assign port_clr[0]  = 1'b0;
	assign port_pwr[0]  = 1'b0;

	// ==========================================================
	// per-port steering and power flops
	genvar n;
	generate
		for (n = 1; n <= `RHPD_MAX_PORTS; n++) begin : g_port
			wire masked = per_port & port_power_mask_r[n];
			assign port_here[n] = (n <= NPORTS);
			// masked ports see only their own commands
			assign port_set[n] = ganged ? gang_set
				: masked ? port_set_pwr_i[n]
				: set_global_power;
			assign port_clr[n] = ganged ? gang_clr
				: masked ? port_clr_pwr_i[n]
				: clr_global_power;
			rhpd_port_pwr u_pwr (
				.mclk_i      (mclk_i),
				.reset_i     (reset_i),
				.port_here_i (port_here[n]),
				.always_on_i (no_power_switch_flag_r),
				.set_i       (port_set[n]),
				.clr_i       (port_clr[n]),
				.pwr_o       (port_pwr[n])
			);
		end
	endgenerate

	assign port_pwr_o             = port_pwr;
	assign no_power_switch_flag_o = no_power_switch_flag_r;
	assign device_fixed_bits_o    = device_fixed_bits_r;

	// ==========================================================
	// checks; modes taken straight from the register bits so that a
	// broken mode decode cannot hide behind its own expression
	wire        chk_gang  = !no_power_switch_flag_r
		&& !power_switch_mode_sel_r;
	wire        chk_port  = !no_power_switch_flag_r
		&& power_switch_mode_sel_r;
	wire [15:0] chk_ports = TWO_PORT ? 16'h0006 : 16'h0002;

	sequence s_ganged_on;
		chk_gang && set_global_power;
	endsequence

	sequence s_ganged_off;
		chk_gang && clr_global_power && !set_global_power
			&& !(|port_set_pwr_i[15:1]);
	endsequence

	// port 2 is the masked port the bench exercises
	sequence s_masked_set;
		chk_port && port_power_mask_r[2] && port_set_pwr_i[2];
	endsequence

	sequence s_masked_quiet;
		chk_port && port_power_mask_r[2] && !port_set_pwr_i[2]
			&& !port_clr_pwr_i[2];
	endsequence

	a_always_powered: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		no_power_switch_flag_r |=> (port_pwr_o == chk_ports))
		else $error("port unpowered while no power switching");

	a_mode_ignored: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		no_power_switch_flag_r && power_switch_mode_sel_r
			&& (|port_clr_pwr_i[15:1]) ##1 no_power_switch_flag_r
			|-> port_pwr_o == chk_ports)
		else $error("mode select acted while no power switching");

	a_ganged_on: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		s_ganged_on |=> (port_pwr_o == chk_ports))
		else $error("ganged set did not power all ports");

	a_gang_port_cmd: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		chk_gang && (|port_set_pwr_i[15:1])
			|=> (port_pwr_o == chk_ports))
		else $error("ganged port command did not power all ports");

	a_unmasked_refuse: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		chk_port && !port_power_mask_r[1] && !set_global_power
			&& !clr_global_power |=> $stable(port_pwr_o[1]))
		else $error("unmasked port followed a port command");

	a_masked_hold: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		s_masked_quiet |=> $stable(port_pwr_o[2]))
		else $error("masked port followed a foreign command");

	a_port_count: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		reg_rd_i && sel_a |=> reg_rdata_o[7:0] >= 8'h01
			&& reg_rdata_o[7:0] <= 8'h0F)
		else $error("port count out of range");

	a_count_value: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		reg_rd_i && sel_a |=> reg_rdata_o[7:0]
			== (TWO_PORT ? 8'h02 : 8'h01))
		else $error("port count not the built value");

	a_mask_field: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		reg_rd_i && sel_b |=> reg_rdata_o[31:16]
			== $past(port_power_mask_r) && !reg_rdata_o[16])
		else $error("mask field misplaced");

	a_mask_ro_bits: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		wr_b |=> !port_power_mask_r[0] && !port_power_mask_r[11]
			&& !device_fixed_bits_r[0])
		else $error("read-only descriptor bit took a write");

	a_mask_ignored: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		s_ganged_off |=> (port_pwr_o == 16'h0000))
		else $error("mask acted in ganged mode");

	a_fixed_bit0: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		reg_rd_i && sel_b |=> !reg_rdata_o[0]
			&& reg_rdata_o[15:1] == $past(device_fixed_bits_r[15:1]))
		else $error("device fixed bits misread");

	a_mask_reset: assert property (
		@(posedge mclk_i)
		$fell(reset_i) |-> port_power_mask_r[1]
			&& port_power_mask_r[2] == TWO_PORT
			&& (port_power_mask_r & 16'hFFF9) == 16'h0000
			&& port_pwr_o == 16'h0000)
		else $error("mask reset value wrong");

	a_zero_no_effect: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		wr_stat && reg_wdata_i == 32'h0000_0000 && chk_gang
			&& !any_set && !any_clr |=> $stable(port_pwr_o))
		else $error("writing zero changed port power");

	a_unmasked_set: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		chk_port && set_global_power && !port_power_mask_r[1]
			|=> port_pwr_o[1])
		else $error("unmasked port missed global set");

	a_masked_global: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		s_masked_quiet ##0 set_global_power |=> $stable(port_pwr_o[2]))
		else $error("masked port took global set");

	// a one-port build has no port 2, so its power must stay off
	a_port_edge: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		s_masked_set |=> port_pwr_o[2] == TWO_PORT)
		else $error("port power not set on next edge");

	a_clr_edge: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		chk_port && !port_power_mask_r[1] && clr_global_power
			&& !set_global_power |=> !port_pwr_o[1])
		else $error("port power not cleared on next edge");

endmodule // rhpd_top

`default_nettype wire

/* File: src/rhpd_cfg.svh */
// Purpose: offsets, field positions and reset values of the root hub
//          port power descriptor block
// Assumes: byte offsets within the host controller register space
// Notes:   definitions only
`ifndef RHPD_CFG_SVH
`define RHPD_CFG_SVH

// ==========================================================
// register offsets
`define RHPD_OFF_DESC_A      8'h48
`define RHPD_OFF_DESC_B      8'h4C
`define RHPD_OFF_HUB_STAT    8'h50

// ==========================================================
// field positions
`define RHPD_PG_TIME_LSB     24
`define RHPD_NO_OVC_BIT      12
`define RHPD_OVC_MODE_BIT    11
`define RHPD_NO_PWR_SW_BIT   9
`define RHPD_SW_MODE_BIT     8
`define RHPD_SET_GLOBAL_BIT  16
`define RHPD_CLR_GLOBAL_BIT  0
`define RHPD_MAX_PORTS       15

// ==========================================================
// reset values and write masks
`define RHPD_PG_TIME_RST     8'hFF
`define RHPD_NO_OVC_RST      1'b0
`define RHPD_OVC_MODE_RST    1'b1
`define RHPD_NO_PWR_SW_RST   1'b0
`define RHPD_SW_MODE_RST     1'b1
`define RHPD_MASK_RST_1P     16'h0002
`define RHPD_MASK_RST_2P     16'h0006
`define RHPD_FIXED_RST       16'h0000
`define RHPD_MASK_WR         16'hF7FE
`define RHPD_FIXED_WR        16'hFFFE
`define RHPD_NPORT_1P        8'h01
`define RHPD_NPORT_2P        8'h02

`endif

/* File: src/rhpd_pkg.sv */
// Purpose: shared types of the root hub port power descriptor block
// Assumes: constants live in rhpd_cfg.svh
// Notes:   types only
package rhpd_pkg;

	// ==========================================================
	// power switching mode as seen by the port logic
	typedef enum logic [1:0] {
		RHPD_SW_NONE   = 2'b00,
		RHPD_SW_GANGED = 2'b01,
		RHPD_SW_PORT   = 2'b10
	} rhpd_sw_mode_e;

	typedef logic [15:0] rhpd_portvec_t;

endpackage

/* File: src/rhpd_port_pwr.sv */
// Purpose: power state of one downstream port
// Assumes: set and clear already steered by the switching mode
// Notes:   set wins when both arrive in one cycle
`timescale 1ns/1ps
`default_nettype none

module rhpd_port_pwr (
	input  wire logic mclk_i,
	input  wire logic reset_i,
	input  wire logic port_here_i,
	input  wire logic always_on_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      pwr_o
);

	logic pwr_r;
	logic pwr_nxt;

	// ==========================================================
	// next power state
	always_comb begin
		pwr_nxt = pwr_r;
		if (set_i)
			pwr_nxt = 1'b1;
		else if (clr_i)
			pwr_nxt = 1'b0;
		if (always_on_i)
			pwr_nxt = 1'b1;
		if (!port_here_i)
			pwr_nxt = 1'b0;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i)
			pwr_r <= 1'b0;
		else
			pwr_r <= pwr_nxt;
	end

	assign pwr_o = pwr_r;

endmodule // rhpd_port_pwr

`default_nettype wire

/* File: test/rhpd_top_bench.sv */
// Purpose: self-checking bench for the root hub port power descriptor block
// Assumes: two-port instance under test, one-port instance for reset values and no-switch port power
// Notes:   inputs change on the falling edge, outputs sampled there too
`timescale 1ns/1ps
`default_nettype none

`include "rhpd_cfg.svh"

module rhpd_top_bench;
	import rhpd_pkg::*;

	// ==========================================================
	// stimulus and observed signals
	logic          mclk_i;
	logic          reset_i;
	logic [7:0]    reg_addr_i;
	logic          reg_wr_i;
	logic          reg_rd_i;
	logic [31:0]   reg_wdata_i;
	logic [31:0]   reg_rdata_o;
	logic [31:0]   rdata_1p;
	rhpd_portvec_t port_set_pwr_i;
	rhpd_portvec_t port_clr_pwr_i;
	rhpd_portvec_t port_pwr_o;
	rhpd_portvec_t pwr_1p;
	logic          no_power_switch_flag_o;
	rhpd_portvec_t device_fixed_bits_o;
	integer        failures;
	integer        cmp_count;

	rhpd_top #(.TWO_PORT(1'b1)) rhpd_top_inst (
		.mclk_i                 (mclk_i),
		.reset_i                (reset_i),
		.reg_addr_i             (reg_addr_i),
		.reg_wr_i               (reg_wr_i),
		.reg_rd_i               (reg_rd_i),
		.reg_wdata_i            (reg_wdata_i),
		.reg_rdata_o            (reg_rdata_o),
		.port_set_pwr_i         (port_set_pwr_i),
		.port_clr_pwr_i         (port_clr_pwr_i),
		.port_pwr_o             (port_pwr_o),
		.no_power_switch_flag_o (no_power_switch_flag_o),
		.device_fixed_bits_o    (device_fixed_bits_o)
	);

	// one-port build shares all inputs; only its reads and power are judged
	rhpd_top #(.TWO_PORT(1'b0)) rhpd_top_1p_inst (
		.mclk_i                 (mclk_i),
		.reset_i                (reset_i),
		.reg_addr_i             (reg_addr_i),
		.reg_wr_i               (reg_wr_i),
		.reg_rd_i               (reg_rd_i),
		.reg_wdata_i            (reg_wdata_i),
		.reg_rdata_o            (rdata_1p),
		.port_set_pwr_i         (port_set_pwr_i),
		.port_clr_pwr_i         (port_clr_pwr_i),
		.port_pwr_o             (pwr_1p),
		.no_power_switch_flag_o (),
		.device_fixed_bits_o    ()
	);

	// ==========================================================
	// clock and shared tasks
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic close_out;
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge mclk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge mclk_i);
		reg_wr_i = 1'b0;
	endtask

	// read data is registered at the taking edge and looked at after it
	task automatic rd(input logic [7:0] a);
		@(negedge mclk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge mclk_i);
		reg_rd_i = 1'b0;
	endtask

	// the power flops take the command at the edge it is held for; the check waits one extra cycle
	task automatic pcmd(input logic [15:0] s, input logic [15:0] c,
			input logic [15:0] e);
		@(negedge mclk_i);
		port_set_pwr_i = s;
		port_clr_pwr_i = c;
		@(negedge mclk_i);
		port_set_pwr_i = 16'h0000;
		port_clr_pwr_i = 16'h0000;
		@(negedge mclk_i);
		chk(32'(port_pwr_o), 32'(e));
	endtask

	task automatic gwr(input logic [31:0] d, input logic [15:0] e);
		wr(`RHPD_OFF_HUB_STAT, d);
		@(negedge mclk_i);
		chk(32'(port_pwr_o), 32'(e));
	endtask

	// ==========================================================
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		#50000;
		failures = failures + 1;
		close_out();
	end

	// ==========================================================
	// main sequence
	initial begin
		failures = 0;
		cmp_count = 0;
		reset_i = 1'b1;
		reg_addr_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_wdata_i = 32'h0000_0000;
		port_set_pwr_i = 16'h0000;
		port_clr_pwr_i = 16'h0000;
		repeat (8) @(posedge mclk_i);
		@(negedge mclk_i);
		reset_i = 1'b0;
		chk(32'(port_pwr_o), 32'h0);
		chk(32'(no_power_switch_flag_o), 32'h0);
		chk(32'(device_fixed_bits_o), 32'h0);
		rd(`RHPD_OFF_DESC_A);
		chk(reg_rdata_o, 32'hFF00_0902);
		chk(rdata_1p, 32'hFF00_0901);
		@(negedge mclk_i);
		chk(reg_rdata_o, 32'h0);
		rd(`RHPD_OFF_DESC_B);
		chk(reg_rdata_o, 32'h0006_0000);
		chk(rdata_1p, 32'h0002_0000);
		wr(`RHPD_OFF_DESC_B, 32'hFFFF_FFFF);
		rd(`RHPD_OFF_DESC_B);
		chk(reg_rdata_o, 32'hF7FE_FFFE);
		chk(32'(device_fixed_bits_o), 32'hFFFE);
		// both ports masked: a global set must leave them off
		gwr(32'h0001_0000, 16'h0000);
		// port 2 masked, port 1 follows the global switch
		wr(`RHPD_OFF_DESC_B, 32'h0004_0006);
		chk(32'(device_fixed_bits_o), 32'h0006);
		gwr(32'h0001_0000, 16'h0002);
		pcmd(16'h0000, 16'h0002, 16'h0002);
		pcmd(16'h0004, 16'h0000, 16'h0006);
		gwr(32'h0000_0001, 16'h0004);
		pcmd(16'h0000, 16'h0004, 16'h0000);
		// ganged mode; type and port count bits must not take the write
		wr(`RHPD_OFF_DESC_A, 32'hFF00_0C00);
		rd(`RHPD_OFF_DESC_A);
		chk(reg_rdata_o, 32'hFF00_0802);
		gwr(32'h0000_0000, 16'h0000);
		gwr(32'h0001_0000, 16'h0006);
		gwr(32'h0000_0001, 16'h0000);
		pcmd(16'h0002, 16'h0000, 16'h0006);
		pcmd(16'h0000, 16'h0004, 16'h0000);
		// no switching: every existing port held on, commands refused
		wr(`RHPD_OFF_DESC_A, 32'hFF00_0A00);
		@(negedge mclk_i);
		chk(32'(port_pwr_o), 32'h0006);
		chk(32'(pwr_1p), 32'h0002);
		chk(32'(no_power_switch_flag_o), 32'h1);
		gwr(32'h0000_0001, 16'h0006);
		wr(`RHPD_OFF_DESC_A, 32'hFF00_0B00);
		pcmd(16'h0000, 16'h0006, 16'h0006);
		rd(`RHPD_OFF_HUB_STAT);
		chk(reg_rdata_o, 32'h0);
		rd(8'h10);
		chk(reg_rdata_o, 32'h0);
		close_out();
	end

endmodule // rhpd_top_bench

`default_nettype wire
